/* File: logic/lbb_bridge.sv */
`timescale 1ns/1ps
module lbb_bridge
  import lbb_pkg::*;
#(
  parameter int HOLD_BASE = HOLD_BASE_LOCAL_CLK_OUT
)
(
  input  wire logic          CLK_SYS,
  input  wire logic          RST,
  input  wire logic          SOFT_RST,
  input  wire lbb_host_req_t HOST_REQ,
  output      lbb_host_ans_t HOST_ANS,
  input  wire lbb_reg_req_t  REG_REQ,
  output      lbb_reg_ans_t  REG_ANS,
  input  wire logic          CONFIG_SELECT_IN,
  output      logic          CONFIG_SELECT_EFF,
  output      logic          LOCAL_IRQ_FLAG,
  output      logic          LOCAL_BUS_ERROR_FLAG,
  input  wire logic          IRQ_FLAG_CLR,
  input  wire logic          LBE_FLAG_CLR,
  input  wire logic          IRQ_MASK_REG,
  output      logic          HOST_IRQ_OUT_N,
  input  wire logic          MODE_CONFIG_PIN,
  input  wire logic          STROBE_STYLE_SEL,
  output      logic          LOCAL_CLK_OUT,
  output      logic          LOCAL_CLK_OE,
  output      logic          HOLD_REQUEST_O,
  output      logic          HOLD_REQUEST_OE,
  input  wire logic          HOLD_GRANT_I,
  output      logic          GRANT_ACK_N_O,
  output      logic          GRANT_ACK_N_OE,
  input  wire logic          EXT_READY_N_I,
  input  wire logic          EXT_IRQ_IN_N_I,
  input  wire logic          LOCAL_CS_N_I,
  input  wire logic [19:0]   LOCAL_ADDR_I,
  output      logic [19:0]   LOCAL_ADDR_O,
  output      logic          LOCAL_ADDR_OE,
  input  wire logic [15:0]   LOCAL_DATA_I,
  output      logic [15:0]   LOCAL_DATA_O,
  output      logic [1:0]    LOCAL_DATA_OE,
  output      logic          LOCAL_BYTE_HI_N_O,
  output      logic          LOCAL_BYTE_HI_N_OE,
  input  wire logic          LOCAL_WR_N_I,
  output      logic          LOCAL_WR_N_O,
  output      logic          LOCAL_WR_N_OE,
  input  wire logic          LOCAL_RD_N_I,
  output      logic          LOCAL_RD_N_O,
  output      logic          LOCAL_RD_N_OE,
  output      lbb_cfg_acc_t  CFG_ACC,
  input  wire logic [15:0]   CFG_RDATA
);

  // ****************************************************************
  // byte lane decode
  // ****************************************************************
  // shift is how far the host word moves to land on the local data pins
  function automatic lbb_lane_t lane_decode(input logic [3:0] be_n, input logic bus8);
    lbb_lane_t l;
    l = '0;
    l.bhe_n = 1'b1;
    case (be_n)
      4'hE:
      begin
        l.ok = 1'b1;
      end
      4'hD:
      begin
        l.ok    = 1'b1;
        l.a0    = 1'b1;
        l.bhe_n = bus8;
        l.shift = bus8 ? 5'h08 : 5'h00;
      end
      4'hC:
      begin
        l.ok    = ~bus8;
        l.bhe_n = 1'b0;
      end
      4'hB:
      begin
        l.ok    = 1'b1;
        l.a1    = 1'b1;
        l.shift = 5'h10;
      end
      4'h7:
      begin
        l.ok    = 1'b1;
        l.a1    = 1'b1;
        l.a0    = 1'b1;
        l.bhe_n = bus8;
        l.shift = bus8 ? 5'h18 : 5'h10;
      end
      4'h3:
      begin
        l.ok    = ~bus8;
        l.a1    = 1'b1;
        l.bhe_n = 1'b0;
        l.shift = 5'h10;
      end
      default:
      begin
        l.ok = 1'b0;
      end
    endcase
    return l;
  endfunction

  lbb_regs_t     s_r;
  lbb_regs_t     s_nxt;
  lbb_pins_t     pins_in;
  logic          bridge;
  logic          arb_eff;
  logic          bus8_eff;
  logic [3:0]    xlen;
  logic          grant_in;
  logic          bus_own;
  logic          strobe;
  lbb_lane_t     lane;
  logic [15:0]   rd_word;

  // upper address lines are never sampled, so they cannot disturb a configuration access
  assign pins_in = {LOCAL_CS_N_I, LOCAL_WR_N_I, LOCAL_RD_N_I, EXT_IRQ_IN_N_I, HOLD_GRANT_I,
                    EXT_READY_N_I, MODE_CONFIG_PIN, STROBE_STYLE_SEL, LOCAL_ADDR_I[15:0],
                    LOCAL_DATA_I};

  // ****************************************************************
  // effective controls
  // ****************************************************************
  assign bridge   = ~s_r.sync2.cfg_mode;
  assign arb_eff  = bridge & s_r.ctrl[ARBE_BIT];
  assign bus8_eff = bridge & s_r.ctrl[WIDTH_BIT];
  assign xlen     = bridge ? s_r.ctrl[XLEN_LSB +: 4] : XLEN_READY;
  // strobe style also flips the polarity of the request and grant pins
  assign grant_in = s_r.sync2.style ? ~s_r.sync2.grant : s_r.sync2.grant;
  assign bus_own  = ~arb_eff | s_r.gack;
  assign strobe   = (s_r.st == ST_XFER);
  assign lane     = lane_decode(HOST_REQ.be_n, bus8_eff);
  assign rd_word  = s_r.bus8 ? {8'h00, s_r.sync2.data[7:0]} : s_r.sync2.data;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    s_nxt             = s_r;
    s_nxt.sync1       = pins_in;
    s_nxt.sync2       = s_r.sync1;
    s_nxt.cs_prev     = s_r.sync2.cs_n;
    s_nxt.local_clk_out        = ~s_r.local_clk_out;
    s_nxt.ans.done    = 1'b0;
    s_nxt.ans.retry   = 1'b0;
    s_nxt.ans.abort   = 1'b0;
    s_nxt.reg_ans.ack = 1'b0;
    s_nxt.cfg.req     = 1'b0;

    // control register, host side only
    if (REG_REQ.req)
    begin
      s_nxt.reg_ans.ack   = 1'b1;
      s_nxt.reg_ans.rdata = 16'h0000;
      if (bridge && (REG_REQ.addr == LBC_OFFSET))
      begin
        s_nxt.reg_ans.rdata = s_r.ctrl;
        if (REG_REQ.wr)
        begin
          s_nxt.ctrl = REG_REQ.wdata & LBC_WMASK;
        end
      end
    end

    // interrupt and error flags: a set in the clearing cycle wins
    if (IRQ_FLAG_CLR)
    begin
      s_nxt.irq_flag = 1'b0;
    end
    if (bridge && !s_r.sync2.irq_n)
    begin
      s_nxt.irq_flag = 1'b1;
    end
    if (LBE_FLAG_CLR)
    begin
      s_nxt.lbe_flag = 1'b0;
    end
    s_nxt.irq_out_n = ~(s_r.irq_flag & ~IRQ_MASK_REG);

    // arbitration and hold timer
    if (!arb_eff)
    begin
      s_nxt.hold_req = 1'b0;
      s_nxt.gack     = 1'b0;
      s_nxt.hold_cnt = '0;
    end
    else if (s_r.hold_req && grant_in && !s_r.gack)
    begin
      s_nxt.gack     = 1'b1;
      s_nxt.hold_cnt = HOLD_CNT_W'(HOLD_BASE) << s_r.ctrl[HOLDT_LSB +: 4];
    end
    else if (s_r.gack)
    begin
      if (s_r.hold_cnt != '0)
      begin
        if (s_r.local_clk_out)
        begin
          s_nxt.hold_cnt = HOLD_CNT_W'(s_r.hold_cnt - 1'b1);
        end
      end
      else if (s_r.st == ST_IDLE)
      begin
        // expiry waits for a running transaction to finish first
        s_nxt.gack     = 1'b0;
        s_nxt.hold_req = 1'b0;
      end
    end

    // transaction sequencer
    case (s_r.st)
      ST_IDLE:
      begin
        if (HOST_REQ.req)
        begin
          if (!bridge)
          begin
            s_nxt.ans.abort = 1'b1;
          end
          else if (HOST_REQ.be_n == 4'hF)
          begin
            s_nxt.ans.done = 1'b1;
          end
          else if (!lane.ok)
          begin
            s_nxt.ans.abort = 1'b1;
          end
          else if (arb_eff && !(s_r.gack && (s_r.hold_cnt >= HOLD_CNT_W'(HOLD_MARGIN_LOCAL_CLK_OUT))))
          begin
            // retry now and fetch the bus, so the host's next try can proceed
            s_nxt.ans.retry = 1'b1;
            if (!s_r.gack)
            begin
              s_nxt.hold_req = 1'b1;
            end
          end
          else
          begin
            s_nxt.st     = ST_XFER;
            s_nxt.cnt    = 4'h0;
            s_nxt.tmo    = 5'h00;
            s_nxt.wr     = HOST_REQ.wr;
            s_nxt.bus8   = bus8_eff;
            s_nxt.shift  = lane.shift;
            s_nxt.addr_o = {HOST_REQ.addr[19:2], lane.a1, lane.a0};
            s_nxt.bhe_n  = lane.bhe_n;
            s_nxt.data_o = 16'(HOST_REQ.wdata >> lane.shift);
          end
        end
      end
      ST_XFER:
      begin
        s_nxt.tmo = 5'(s_r.tmo + 1'b1);
        if (s_r.local_clk_out && (s_r.tmo != 5'h00))
        begin
          s_nxt.cnt = 4'(s_r.cnt + 1'b1);
        end
        if (xlen == XLEN_READY)
        begin
          if (!s_r.sync2.ready_n)
          begin
            s_nxt.st        = ST_TURN;
            s_nxt.ans.done  = 1'b1;
            s_nxt.ans.rdata = 32'(rd_word) << s_r.shift;
          end
          // 16 host clocks run out before the 9th local clock, so one check covers both
          else if (s_r.tmo == 5'(TIMEOUT_PCLK - 1))
          begin
            s_nxt.st        = ST_TURN;
            s_nxt.ans.retry = 1'b1;
            s_nxt.lbe_flag  = 1'b1;
          end
        end
        // illegal codes are clamped to the longest legal length
        else if (s_r.local_clk_out && (s_r.tmo != 5'h00) &&
                 (4'(s_r.cnt + 1'b1) >= ((xlen > XLEN_MAX) ? XLEN_MAX : xlen)))
        begin
          s_nxt.st        = ST_TURN;
          s_nxt.ans.done  = 1'b1;
          s_nxt.ans.rdata = 32'(rd_word) << s_r.shift;
        end
      end
      ST_TURN:
      begin
        s_nxt.st = ST_IDLE;
      end
      default:
      begin
        s_nxt.st = ST_IDLE;
      end
    endcase

    // configuration port: whole 16-bit words, upper address lines never seen
    if (!bridge)
    begin
      s_nxt.cfg_drive = ~s_r.sync2.cs_n & ~s_r.sync2.rd_n;
      s_nxt.data_o    = CFG_RDATA;
      if (s_r.cs_prev && !s_r.sync2.cs_n)
      begin
        // cs, address and data pass the same two stages, so they are captured from one sample
        s_nxt.cfg.req   = 1'b1;
        s_nxt.cfg.wr    = ~s_r.sync2.wr_n;
        s_nxt.cfg.addr  = s_r.sync2.addr;
        s_nxt.cfg.wdata = s_r.sync2.data;
      end
    end
    else
    begin
      s_nxt.cfg_drive = 1'b0;
    end

    // software reset leaves the control register alone
    if (SOFT_RST)
    begin
      s_nxt.st       = ST_IDLE;
      s_nxt.irq_flag = 1'b0;
      s_nxt.lbe_flag = 1'b0;
      s_nxt.hold_req = 1'b0;
      s_nxt.gack     = 1'b0;
      s_nxt.hold_cnt = '0;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      s_r           <= '0;
      s_r.ctrl      <= LBC_RESET;
      s_r.sync1     <= PIN_IDLE;
      s_r.sync2     <= PIN_IDLE;
      s_r.st        <= ST_IDLE;
      s_r.irq_out_n <= 1'b1;
      s_r.bhe_n     <= 1'b1;
      s_r.cs_prev   <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign HOST_ANS             = s_r.ans;
  assign REG_ANS              = s_r.reg_ans;
  assign CFG_ACC              = s_r.cfg;
  assign CONFIG_SELECT_EFF    = CONFIG_SELECT_IN & bridge;
  assign LOCAL_IRQ_FLAG       = s_r.irq_flag;
  assign LOCAL_BUS_ERROR_FLAG = s_r.lbe_flag;
  assign HOST_IRQ_OUT_N       = s_r.irq_out_n;

  // the local clock is the system clock halved, so one local clock is two host clocks
  assign LOCAL_CLK_OUT        = s_r.local_clk_out;
  assign LOCAL_CLK_OE         = bridge & s_r.ctrl[CLKOE_BIT];

  assign HOLD_REQUEST_O       = s_r.sync2.style ? ~s_r.hold_req : s_r.hold_req;
  assign HOLD_REQUEST_OE      = arb_eff;
  assign GRANT_ACK_N_O        = ~s_r.gack;
  assign GRANT_ACK_N_OE       = arb_eff;

  assign LOCAL_ADDR_O         = s_r.addr_o;
  assign LOCAL_ADDR_OE        = bridge & bus_own;
  assign LOCAL_BYTE_HI_N_O    = s_r.bhe_n;
  assign LOCAL_BYTE_HI_N_OE   = bridge & bus_own;
  assign LOCAL_DATA_O         = s_r.data_o;
  assign LOCAL_DATA_OE        = {(strobe & s_r.wr & ~s_r.bus8) | s_r.cfg_drive,
                                 (strobe & s_r.wr) | s_r.cfg_drive};

  // write strobe and read/write level share one equation; the read pin is a data strobe when style is set
  assign LOCAL_WR_N_O         = ~(strobe & s_r.wr);
  assign LOCAL_RD_N_O         = s_r.sync2.style ? ~strobe : ~(strobe & ~s_r.wr);
  assign LOCAL_WR_N_OE        = bridge & bus_own;
  assign LOCAL_RD_N_OE        = bridge & bus_own;

endmodule

/* File: include/lbb_pkg.sv */
// Contract
// - in bridge mode an asserted external interrupt input sets the local interrupt flag
// - a set local interrupt flag raises the host interrupt unless masked
// - configuration mode ignores the host configuration select input
// - configuration mode passes no local bus data to the host
// - configuration mode disables arbitration, width formatting and programmed transaction length
// - configuration accesses use 16-bit address and 16-bit data, never bytes
// - configuration mode ignores the four upper local address lines
// - control register at 0x040, reachable only in bridge mode
// - control register clears on hardware reset, survives software reset
// - control bit 0 drives the local clock pin, else tri-stated
// - control bit 1 enables hold, grant and grant acknowledge handshake
// - hold timer runs only while arbitration is enabled
// - bits 5..2 select ready-ended (0000) or fixed 1..11 clock transactions
// - control bit 6 selects 16-bit (0) or 8-bit (1) data bus
// - bits 11..8 set hold time, 32 clocks doubling up to 1048576
// - hold time runs from grant detection to grant acknowledge release
// - ungranted access requests the bus; granted access proceeds directly if 16 or more hold clocks remain
// - ready must come by the 9th local clock, else error flag
// - strobe style input selects read/write plus data strobe convention
// - ready-ended bridged access over 16 host clocks ends with retry and error flag
// - unsupported byte enable pattern gets target abort and no local cycle
package lbb_pkg;

  // ****************************************************************
  // register map and fields
  // ****************************************************************
  localparam logic [7:0]  LBC_OFFSET       = 8'h40;
  localparam logic [15:0] LBC_RESET        = 16'h0000;
  localparam logic [15:0] LBC_WMASK        = 16'h0F7F;
  localparam int          CLKOE_BIT        = 0;
  localparam int          ARBE_BIT         = 1;
  localparam int          XLEN_LSB         = 2;
  localparam int          WIDTH_BIT        = 6;
  localparam int          HOLDT_LSB        = 8;
  localparam logic [3:0]  XLEN_READY       = 4'h0;
  localparam logic [3:0]  XLEN_MAX         = 4'hB;
  localparam logic [39:0] PIN_IDLE         = 40'hF400000000;

  // ****************************************************************
  // timing counts
  // ****************************************************************
  localparam int          HOLD_BASE_LOCAL_CLK_OUT   = 32;
  localparam int          HOLD_CNT_W       = 21;
  localparam int          HOLD_MARGIN_LOCAL_CLK_OUT = 16;
  localparam int          READY_LIMIT_LOCAL_CLK_OUT = 9;
  localparam int          TIMEOUT_PCLK     = 16;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_XFER = 3'b010,
    ST_TURN = 3'b100
  } lbb_state_t;

  typedef struct packed {
    logic        req;
    logic        wr;
    logic [19:0] addr;
    logic [3:0]  be_n;
    logic [31:0] wdata;
  } lbb_host_req_t;

  typedef struct packed {
    logic        done;
    logic        retry;
    logic        abort;
    logic [31:0] rdata;
  } lbb_host_ans_t;

  typedef struct packed {
    logic        req;
    logic        wr;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } lbb_reg_req_t;

  typedef struct packed {
    logic        ack;
    logic [15:0] rdata;
  } lbb_reg_ans_t;

  typedef struct packed {
    logic        req;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } lbb_cfg_acc_t;

  typedef struct packed {
    logic        ok;
    logic        a1;
    logic        a0;
    logic        bhe_n;
    logic [4:0]  shift;
  } lbb_lane_t;

  typedef struct packed {
    logic        cs_n;
    logic        wr_n;
    logic        rd_n;
    logic        irq_n;
    logic        grant;
    logic        ready_n;
    logic        cfg_mode;
    logic        style;
    logic [15:0] addr;
    logic [15:0] data;
  } lbb_pins_t;

  typedef struct packed {
    lbb_pins_t               sync1;
    lbb_pins_t               sync2;
    logic                    cs_prev;
    logic [15:0]             ctrl;
    lbb_state_t              st;
    logic                    local_clk_out;
    logic [3:0]              cnt;
    logic [4:0]              tmo;
    logic                    hold_req;
    logic                    gack;
    logic [HOLD_CNT_W-1:0]   hold_cnt;
    logic                    irq_flag;
    logic                    lbe_flag;
    logic                    irq_out_n;
    lbb_host_ans_t           ans;
    lbb_reg_ans_t            reg_ans;
    lbb_cfg_acc_t            cfg;
    logic                    wr;
    logic                    bus8;
    logic [4:0]              shift;
    logic [19:0]             addr_o;
    logic                    bhe_n;
    logic [15:0]             data_o;
    logic                    cfg_drive;
  } lbb_regs_t;

endpackage

/* File: tb/lbb_bridge_sva.sv */
`timescale 1ns/1ps
module lbb_bridge_sva
  import lbb_pkg::*;
(
  input wire logic          CLK_SYS,
  input wire logic          RST,
  input wire logic          SOFT_RST,
  input wire lbb_host_req_t HOST_REQ,
  input wire lbb_host_ans_t HOST_ANS,
  input wire lbb_reg_req_t  REG_REQ,
  input wire lbb_reg_ans_t  REG_ANS,
  input wire logic          LOCAL_IRQ_FLAG,
  input wire logic          IRQ_MASK_REG,
  input wire logic          HOST_IRQ_OUT_N,
  input wire logic          MODE_CONFIG_PIN,
  input wire logic          LOCAL_CLK_OE,
  input wire logic          HOLD_REQUEST_O,
  input wire logic          HOLD_REQUEST_OE,
  input wire logic          GRANT_ACK_N_O,
  input wire logic          GRANT_ACK_N_OE,
  input wire logic          EXT_IRQ_IN_N_I,
  input wire logic          LOCAL_ADDR_OE
);
  // ****************************************************************
  // control register shadow
  // ****************************************************************
  // config-mode writes are dropped, so the shadow skips them too
  logic [15:0] sh_r;
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      sh_r <= LBC_RESET;
    else if (REG_REQ.req && REG_REQ.wr && REG_REQ.addr == LBC_OFFSET && !MODE_CONFIG_PIN)
      sh_r <= REG_REQ.wdata & LBC_WMASK;
  end
  default clocking dc @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);
  // ****************************************************************
  // properties
  // ****************************************************************
  property p_reg_ack;
    REG_REQ.req |=> REG_ANS.ack;
  endproperty
  a_reg_ack: assert property (p_reg_ack) else $error("no reg ack");
  property p_reg_rd;
    ((!MODE_CONFIG_PIN)[*5] ##0 (REG_REQ.req && !REG_REQ.wr && REG_REQ.addr == LBC_OFFSET))
      |=> REG_ANS.rdata == sh_r;
  endproperty
  a_reg_rd: assert property (p_reg_rd) else $error("ctrl readback wrong");
  property p_clk_oe;
    ((!MODE_CONFIG_PIN)[*5] ##0 $stable(sh_r)[*2]) |-> LOCAL_CLK_OE == sh_r[CLKOE_BIT];
  endproperty
  a_clk_oe: assert property (p_clk_oe) else $error("clock enable wrong");
  property p_cfg_off;
    MODE_CONFIG_PIN[*5] |-> !(LOCAL_CLK_OE || HOLD_REQUEST_OE || GRANT_ACK_N_OE);
  endproperty
  a_cfg_off: assert property (p_cfg_off) else $error("arbitration pins live in config mode");
  property p_irq_set;
    (!EXT_IRQ_IN_N_I && !MODE_CONFIG_PIN && !SOFT_RST)[*4] |-> LOCAL_IRQ_FLAG;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("irq flag not set");
  property p_irq_out;
    (LOCAL_IRQ_FLAG && !IRQ_MASK_REG && !MODE_CONFIG_PIN)[*3] |-> !HOST_IRQ_OUT_N;
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("host irq not raised");
  property p_bad_be;
    ((!MODE_CONFIG_PIN)[*5] ##0 (HOST_REQ.req && HOST_REQ.be_n == 4'h5)) |=> ##[0:1] HOST_ANS.abort;
  endproperty
  a_bad_be: assert property (p_bad_be) else $error("bad lanes not aborted");
  property p_answer;
    HOST_REQ.req |-> ##[1:40] (HOST_ANS.done || HOST_ANS.retry || HOST_ANS.abort);
  endproperty
  a_answer: assert property (p_answer) else $error("host access never answered");
  property p_hold;
    ($rose(GRANT_ACK_N_O) && GRANT_ACK_N_OE) |-> ##[0:2] (!HOLD_REQUEST_O && !LOCAL_ADDR_OE);
  endproperty
  a_hold: assert property (p_hold) else $error("bus not released");
endmodule
bind lbb_bridge lbb_bridge_sva u_sva (.*);

/* File: tb/lbb_periph.sv */
`timescale 1ns/1ps
module lbb_periph
#(
  parameter logic [15:0] RVAL = 16'h1234
)
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        strobe_n,
  input  wire logic        hreq,
  input  wire logic [4:0]  dly,
  output      logic        ready_n,
  output      logic        grant,
  output      logic [15:0] data
);
  logic [4:0]  cnt_r;
  logic [15:0] last_r;
  always_ff @(posedge clk)
  begin
    if (rst || strobe_n)
      cnt_r <= 5'h00;
    else if (cnt_r != 5'h1F)
      cnt_r <= cnt_r + 5'h01;
    if (rst)
      last_r <= 16'h0000;
    else if (!strobe_n)
      last_r <= RVAL;
    grant <= hreq && !rst;
  end
  // ready holds until the strobe ends; a delay of zero stalls for ever
  assign ready_n = !(!strobe_n && dly != 5'h00 && cnt_r >= dly);
  // released lines show the inverse of the last word, never a stale copy
  assign data = strobe_n ? ~last_r : RVAL;
endmodule

/* File: tb/lbb_bridge_bench.sv */
`timescale 1ns/1ps
module lbb_bridge_bench;
  import lbb_pkg::*;
  logic CLK_SYS = 1'b0, RST = 1'b1, SOFT_RST = 1'b0, IRQ_FLAG_CLR = 1'b0, LBE_FLAG_CLR = 1'b0;
  logic IRQ_MASK_REG = 1'b0, MODE_CONFIG_PIN = 1'b0, STROBE_STYLE_SEL = 1'b0, CONFIG_SELECT_IN = 1'b1;
  logic EXT_IRQ_IN_N_I = 1'b1, LOCAL_CS_N_I = 1'b1, LOCAL_WR_N_I = 1'b1, LOCAL_RD_N_I = 1'b1;
  logic [19:0] LOCAL_ADDR_I = 20'h00000;
  logic [15:0] CFG_RDATA = 16'h5A5A, cfg_d = 16'h0000;
  lbb_host_req_t HOST_REQ = '0;
  lbb_reg_req_t REG_REQ = '0;
  logic [4:0] dly = 5'h00;
  lbb_host_ans_t HOST_ANS;
  lbb_reg_ans_t REG_ANS;
  lbb_cfg_acc_t CFG_ACC;
  logic CONFIG_SELECT_EFF, LOCAL_IRQ_FLAG, LOCAL_BUS_ERROR_FLAG, HOST_IRQ_OUT_N, LOCAL_CLK_OUT, LOCAL_CLK_OE;
  logic HOLD_REQUEST_O, HOLD_REQUEST_OE, HOLD_GRANT_I, GRANT_ACK_N_O, GRANT_ACK_N_OE, EXT_READY_N_I;
  logic LOCAL_ADDR_OE, LOCAL_BYTE_HI_N_O, LOCAL_BYTE_HI_N_OE, LOCAL_WR_N_O, LOCAL_WR_N_OE;
  logic LOCAL_RD_N_O, LOCAL_RD_N_OE, pstb_n, s_bh;
  logic [19:0] LOCAL_ADDR_O;
  logic [15:0] LOCAL_DATA_I, LOCAL_DATA_O, pdata, s_d, rd;
  logic [1:0] LOCAL_DATA_OE, s_a;
  logic [2:0] a_r;
  int errors = 0, n_checks = 0, cyc = 0, n_r, s_cnt, k, ack_cnt;
  assign pstb_n = (LOCAL_WR_N_O | ~LOCAL_WR_N_OE) & (LOCAL_RD_N_O | ~LOCAL_RD_N_OE);
  assign LOCAL_DATA_I = MODE_CONFIG_PIN ? cfg_d : (|LOCAL_DATA_OE ? LOCAL_DATA_O : pdata);
  lbb_bridge #(.HOLD_BASE(2)) u_dut (.*);
  lbb_periph u_periph (.clk(CLK_SYS), .rst(RST), .strobe_n(pstb_n), .hreq(HOLD_REQUEST_O & HOLD_REQUEST_OE),
                       .dly(dly), .ready_n(EXT_READY_N_I), .grant(HOLD_GRANT_I), .data(pdata));
  always #25 CLK_SYS = ~CLK_SYS;
  always @(negedge CLK_SYS)
    if (GRANT_ACK_N_O === 1'b0)
      ack_cnt++;
  always @(posedge CLK_SYS)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      close_out();
    end
  end
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic rg(input logic w, input logic [7:0] ad, input logic [15:0] wd);
    @(negedge CLK_SYS);
    REG_REQ = '{1'b1, w, ad, wd};
    @(negedge CLK_SYS);
    chk("reg ack", REG_ANS.ack, 1'b1);
    rd = REG_ANS.rdata;
    REG_REQ.req = 1'b0;
  endtask
  task automatic pulse(ref logic s);
    @(negedge CLK_SYS);
    s = 1'b1;
    @(negedge CLK_SYS);
    s = 1'b0;
    repeat (3) @(negedge CLK_SYS);
  endtask
  // records what the strobes showed while waiting for the answer
  task automatic hx(input logic w, input logic [3:0] be, input logic [31:0] wd);
    @(negedge CLK_SYS);
    HOST_REQ = '{1'b1, w, 20'h00010, be, wd};
    n_r = 0;
    s_cnt = 0;
    a_r = 3'b000;
    while (a_r == 3'b000 && n_r < 60)
    begin
      @(negedge CLK_SYS);
      HOST_REQ.req = 1'b0;
      n_r++;
      if (!pstb_n)
      begin
        s_cnt++;
        s_a = LOCAL_ADDR_O[1:0];
        s_d = LOCAL_DATA_O;
        s_bh = LOCAL_BYTE_HI_N_O;
      end
      a_r = {HOST_ANS.done, HOST_ANS.retry, HOST_ANS.abort};
    end
    repeat (2) @(negedge CLK_SYS);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reg();
    rg(1'b0, LBC_OFFSET, 16'h0000);
    chk("ctrl reset", rd, 16'h0000);
    chk("sel pass", CONFIG_SELECT_EFF, 1'b1);
    rg(1'b1, LBC_OFFSET, 16'hF0C5);
    rg(1'b0, LBC_OFFSET, 16'h0000);
    chk("ctrl rw", rd, 16'h0045);
    pulse(SOFT_RST);
    rg(1'b0, LBC_OFFSET, 16'h0000);
    chk("ctrl soft", rd, 16'h0045);
    rg(1'b0, 8'h44, 16'h0000);
    chk("unmapped", rd, 16'h0000);
  endtask
  task automatic t_irq();
    pulse(IRQ_FLAG_CLR);
    chk("irq idle", LOCAL_IRQ_FLAG, 1'b0);
    EXT_IRQ_IN_N_I = 1'b0;
    repeat (5) @(negedge CLK_SYS);
    EXT_IRQ_IN_N_I = 1'b1;
    chk("irq flag", LOCAL_IRQ_FLAG, 1'b1);
    chk("irq out", HOST_IRQ_OUT_N, 1'b0);
    IRQ_MASK_REG = 1'b1;
    repeat (3) @(negedge CLK_SYS);
    chk("irq masked", HOST_IRQ_OUT_N, 1'b1);
    IRQ_MASK_REG = 1'b0;
    pulse(IRQ_FLAG_CLR);
    chk("irq cleared", {LOCAL_IRQ_FLAG, HOST_IRQ_OUT_N}, 2'b01);
  endtask
  task automatic t_fixed();
    logic [3:0] codes [3] = '{4'h1, 4'h4, 4'hB};
    dly = 5'h00;
    foreach (codes[i])
    begin
      rg(1'b1, LBC_OFFSET, {8'h00, 2'b01, codes[i], 2'b01});
      hx(1'b1, 4'b1101, 32'h0000AB00);
      chk("fixed done", a_r, 3'b100);
      chk("fixed len", s_cnt >= 2 * codes[i] && s_cnt <= 2 * codes[i] + 2, 1'b1);
      chk("lane", {s_a, s_bh, s_d[7:0]}, 11'h3AB);
    end
    hx(1'b0, 4'b1100, 32'h0);
    chk("8bit word", a_r, 3'b001);
    hx(1'b0, 4'b0101, 32'h0);
    chk("bad lanes", {a_r, s_cnt[3:0]}, 7'h10);
    hx(1'b0, 4'b1111, 32'h0);
    chk("no lanes", {a_r, s_cnt[3:0]}, 7'h40);
  endtask
  task automatic t_ready();
    rg(1'b1, LBC_OFFSET, 16'h0001);
    dly = 5'h04;
    STROBE_STYLE_SEL = 1'b1;
    hx(1'b0, 4'b1100, 32'h0);
    chk("ready done", a_r, 3'b100);
    chk("word read", HOST_ANS.rdata[15:0], 16'h1234);
    chk("no error", LOCAL_BUS_ERROR_FLAG, 1'b0);
    dly = 5'h00;
    hx(1'b0, 4'b1100, 32'h0);
    chk("stall retry", a_r, 3'b010);
    chk("stall time", n_r >= 16 && n_r <= 18, 1'b1);
    chk("error flag", LOCAL_BUS_ERROR_FLAG, 1'b1);
    STROBE_STYLE_SEL = 1'b0;
    pulse(LBE_FLAG_CLR);
    chk("error clr", LOCAL_BUS_ERROR_FLAG, 1'b0);
  endtask
  task automatic t_arb();
    rg(1'b1, LBC_OFFSET, 16'h0407);
    ack_cnt = 0;
    hx(1'b1, 4'b1100, 32'h00005678);
    chk("arb retry", {a_r, s_cnt[3:0]}, 7'h20);
    k = 0;
    while (GRANT_ACK_N_O !== 1'b0 && k < 20)
    begin
      @(negedge CLK_SYS);
      k++;
    end
    hx(1'b1, 4'b1100, 32'h00005678);
    chk("granted done", a_r, 3'b100);
    while (GRANT_ACK_N_O === 1'b0 && k < 200)
    begin
      @(negedge CLK_SYS);
      k++;
    end
    repeat (2) @(negedge CLK_SYS);
    chk("hold time", ack_cnt >= 60 && ack_cnt <= 68, 1'b1);
    chk("released", {HOLD_REQUEST_O, LOCAL_ADDR_OE}, 2'b00);
    rg(1'b1, LBC_OFFSET, 16'h0005);
    hx(1'b1, 4'b1100, 32'h0);
    chk("no arb", {a_r, HOLD_REQUEST_OE}, 4'h8);
  endtask
  task automatic t_cfg();
    MODE_CONFIG_PIN = 1'b1;
    repeat (6) @(negedge CLK_SYS);
    chk("sel gated", CONFIG_SELECT_EFF, 1'b0);
    hx(1'b0, 4'b1100, 32'h0);
    chk("cfg abort", a_r, 3'b001);
    rg(1'b1, LBC_OFFSET, 16'h0001);
    chk("cfg reg", rd, 16'h0000);
    // word-wide write only, never a byte
    LOCAL_ADDR_I = 20'hF1234;
    cfg_d = 16'hBEEF;
    LOCAL_WR_N_I = 1'b0;
    LOCAL_CS_N_I = 1'b0;
    k = 0;
    while (CFG_ACC.req !== 1'b1 && k < 10)
    begin
      @(negedge CLK_SYS);
      k++;
    end
    chk("cfg addr", CFG_ACC.addr, 16'h1234);
    chk("cfg data", {CFG_ACC.wr, CFG_ACC.wdata}, 17'h1BEEF);
    repeat (3) @(negedge CLK_SYS);
    LOCAL_CS_N_I = 1'b1;
    LOCAL_WR_N_I = 1'b1;
    repeat (4) @(negedge CLK_SYS);
    MODE_CONFIG_PIN = 1'b0;
    repeat (6) @(negedge CLK_SYS);
    rg(1'b0, LBC_OFFSET, 16'h0000);
    chk("ctrl kept", rd, 16'h0005);
  endtask
  initial
  begin
    repeat (12) @(negedge CLK_SYS);
    RST = 1'b0;
    repeat (3) @(negedge CLK_SYS);
    t_reg();
    t_irq();
    t_fixed();
    t_ready();
    t_arb();
    t_cfg();
    close_out();
  end
endmodule
